// ---- hdl/ctirb_map.vh ----
/*
 Register offsets, field positions and fixed values of the identity register bank.
 Assumes inclusion by the design files of this block only.
*/
`ifndef CTIRB_MAP_VH
`define CTIRB_MAP_VH

`define CTIRB_ADDR_W            12
`define CTIRB_OFS_ITCTRL        12'hF00
`define CTIRB_OFS_AFFINITY      12'hFA8
`define CTIRB_OFS_CAPABILITY    12'hFC8
`define CTIRB_OFS_PID4          12'hFD0
`define CTIRB_OFS_PID2          12'hFE8
`define CTIRB_OFS_PID3          12'hFEC

`define CTIRB_PID2_REV_LSB      4
`define CTIRB_PID2_JEDEC_BIT    3
`define CTIRB_PID3_MINOR_REVISION_FIELD_LSB   4
`define CTIRB_PID4_SIZE_LSB     4
`define CTIRB_PID4_SIZE_VAL     4'h0
`define CTIRB_ITCTRL_ENABLE_VAL 1'h0
`define CTIRB_AFF_L2_LSB        16
`define CTIRB_AFF_ONE_BIT       15
`define CTIRB_CAP_INOUT_LSB     24
`define CTIRB_CAP_INOUT_VAL     2'h1
`define CTIRB_CAP_CHANNEL_COUNT_FIELD_LSB   16
`define CTIRB_CAP_CHANNEL_COUNT_FIELD_VAL   6'h04
`define CTIRB_CAP_TRIGGER_COUNT_FIELD_LSB   8
`define CTIRB_CAP_TRIGGER_COUNT_FIELD_VAL   6'h0A
`define CTIRB_CAP_EXTMAX_LSB    0
`define CTIRB_CAP_EXTMAX_VAL    5'h00

`define CTIRB_PERM_OFF          3'h0
`define CTIRB_PERM_DLK          3'h1
`define CTIRB_PERM_OS_LOCK_CONDITION         3'h2
`define CTIRB_PERM_EXTERNAL_DEBUG_DISABLED_CONDITION         3'h3
`define CTIRB_PERM_DEFAULT      3'h4

`endif

// ---- hdl/ctirb_sync3.v ----
/*
 Three-flop synchroniser for a bus of static configuration levels.
 Assumes the inputs come from outside the sys_clk domain.
*/
`timescale 1ns/1ps
module ctirb_sync3 #(
   parameter W = 8
) (
   input  wire         sys_clk,
   input  wire         rst_n,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   reg [W-1:0] stage3;

   // A change is taken once the second and third stages agree
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1   <= {W{1'b0}};
         stage2   <= {W{1'b0}};
         stage3   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            sync_out <= stage3;
         end
      end
   end
endmodule // ctirb_sync3

// ---- hdl/ctirb_perm.v ----
/*
 Access permission priority: picks the first true condition for an external access.
 Assumes condition inputs are already in the sys_clk domain.
*/
`timescale 1ns/1ps
`include "ctirb_map.vh"
module ctirb_perm (
   input  wire       powered_up_status_bit,
   input  wire       double_lock_status_bit,
   input  wire       os_lock_status_bit,
   input  wire       debug_allowed,
   output reg  [2:0] perm_code
);
   always @* begin
      if (!powered_up_status_bit) begin
         perm_code = `CTIRB_PERM_OFF;
      end else if (double_lock_status_bit) begin
         perm_code = `CTIRB_PERM_DLK;
      end else if (os_lock_status_bit) begin
         perm_code = `CTIRB_PERM_OS_LOCK_CONDITION;
      end else if (!debug_allowed) begin
         perm_code = `CTIRB_PERM_EXTERNAL_DEBUG_DISABLED_CONDITION;
      end else begin
         perm_code = `CTIRB_PERM_DEFAULT;
      end
   end
endmodule // ctirb_perm

// ---- hdl/ctirb_bank.v ----
/*
 Read-only identity and capability register bank of the cross trigger unit,
 reached through the external debug register port.
 Assumes a single-cycle request/answer port on sys_clk and status levels from
 other domains that pass through synchronisers here.
*/
`timescale 1ns/1ps
`include "ctirb_map.vh"

module ctirb_bank #(
   parameter [3:0] PID2_REVISION    = 4'h0, // Arbitrary value
   parameter [2:0] PID2_DESIGNER_HI = 3'h0, // Arbitrary value
   parameter [3:0] PID3_MINOR_REV   = 4'h0, // Arbitrary value
   parameter [3:0] PID3_CUSTOMER    = 4'h0, // Arbitrary value
   parameter [3:0] PID4_CONT_CODE   = 4'h0, // Arbitrary value
   parameter       HAS_IDENT_REGS   = 1
) (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        req_valid,
   input  wire        req_write,
   input  wire [11:0] req_addr,
   input  wire [31:0] req_wdata,
   output reg         rsp_valid,
   output reg  [31:0] rsp_rdata,
   output reg         rsp_error,
   output reg  [2:0]  rsp_perm,
   input  wire [7:0]  cluster_level2_affinity_in,
   input  wire        powered_up_status_bit,
   input  wire        double_lock_status_bit,
   input  wire        os_lock_status_bit,
   input  wire        debug_allowed,
   input  wire        sticky_clear,
   output reg         sticky_debug_disabled_bit
);
   wire [7:0]  aff_sync;
   wire [3:0]  cond_sync;
   wire [2:0]  perm_code;
   reg  [31:0] next_rdata;
   reg         next_hit;
   wire        external_debug_disabled_condition_err;

   ctirb_sync3 #(.W(8)) u_aff_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (cluster_level2_affinity_in),
      .sync_out (aff_sync)
   );

   ctirb_sync3 #(.W(4)) u_cond_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in ({powered_up_status_bit, double_lock_status_bit,
                  os_lock_status_bit, debug_allowed}),
      .sync_out (cond_sync)
   );

   ctirb_perm u_perm (
      .powered_up_status_bit  (cond_sync[3]),
      .double_lock_status_bit (cond_sync[2]),
      .os_lock_status_bit     (cond_sync[1]),
      .debug_allowed          (cond_sync[0]),
      .perm_code              (perm_code)
   );

   // Read decode, contents do not depend on the condition
   always @* begin
      next_rdata = 32'h00000000;
      next_hit   = 1'b1;
      case (req_addr)
         `CTIRB_OFS_PID2: begin
            next_rdata[7:`CTIRB_PID2_REV_LSB] = PID2_REVISION;
            next_rdata[`CTIRB_PID2_JEDEC_BIT] = 1'b1;
            next_rdata[2:0]                   = PID2_DESIGNER_HI;
            next_hit                          = (HAS_IDENT_REGS != 0);
         end
         `CTIRB_OFS_PID3: begin
            next_rdata[7:`CTIRB_PID3_MINOR_REVISION_FIELD_LSB] = PID3_MINOR_REV;
            next_rdata[3:0]                      = PID3_CUSTOMER;
            next_hit                             = (HAS_IDENT_REGS != 0);
         end
         `CTIRB_OFS_PID4: begin
            next_rdata[7:`CTIRB_PID4_SIZE_LSB] = `CTIRB_PID4_SIZE_VAL;
            next_rdata[3:0]                    = PID4_CONT_CODE;
            next_hit                           = (HAS_IDENT_REGS != 0);
         end
         `CTIRB_OFS_ITCTRL: begin
            next_rdata[0] = `CTIRB_ITCTRL_ENABLE_VAL;
         end
         `CTIRB_OFS_AFFINITY: begin
            next_rdata[23:`CTIRB_AFF_L2_LSB] = aff_sync;
            next_rdata[`CTIRB_AFF_ONE_BIT]   = 1'b1;
            next_hit                         = (HAS_IDENT_REGS != 0);
         end
         `CTIRB_OFS_CAPABILITY: begin
            next_rdata[25:`CTIRB_CAP_INOUT_LSB]   = `CTIRB_CAP_INOUT_VAL;
            next_rdata[21:`CTIRB_CAP_CHANNEL_COUNT_FIELD_LSB] = `CTIRB_CAP_CHANNEL_COUNT_FIELD_VAL;
            next_rdata[13:`CTIRB_CAP_TRIGGER_COUNT_FIELD_LSB] = `CTIRB_CAP_TRIGGER_COUNT_FIELD_VAL;
            next_rdata[4:`CTIRB_CAP_EXTMAX_LSB]   = `CTIRB_CAP_EXTMAX_VAL;
         end
         default: begin
            next_hit = 1'b0;
         end
      endcase
   end

   // Only an access to an unmapped offset while disabled debug is the top condition marks sticky
   assign external_debug_disabled_condition_err = req_valid && (perm_code == `CTIRB_PERM_EXTERNAL_DEBUG_DISABLED_CONDITION) && !next_hit;

   // Answer one cycle after the request; writes store nothing
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 32'h00000000;
         rsp_error <= 1'b0;
         rsp_perm  <= `CTIRB_PERM_OFF;
      end else begin
         rsp_valid <= req_valid;
         rsp_perm  <= perm_code;
         if (req_valid) begin
            rsp_rdata <= (next_hit && !req_write) ? next_rdata : 32'h00000000;
            rsp_error <= !next_hit;
         end
      end
   end

   // Set wins over clear
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sticky_debug_disabled_bit <= 1'b0;
      end else if (external_debug_disabled_condition_err) begin
         sticky_debug_disabled_bit <= 1'b1;
      end else if (sticky_clear) begin
         sticky_debug_disabled_bit <= 1'b0;
      end
   end
endmodule // ctirb_bank

// ---- tb/ctirb_dbg_model.sv ----
/* Debugger model: issues single-word accesses on the request port.
   Assumes the bank answers one cycle after it takes a request. */
`timescale 1ns/1ps
module ctirb_dbg_model (
   input  wire        sys_clk,
   output reg         req_valid,
   output reg         req_write,
   output reg  [11:0] req_addr,
   output reg  [31:0] req_wdata,
   input  wire        rsp_valid,
   input  wire [31:0] rsp_rdata,
   input  wire        rsp_error
);
   initial {req_valid, req_write, req_addr, req_wdata} = 46'h0;
   task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] rd, output er, output ok);
      integer n;
      begin
         ok = 1'b0;
         @(posedge sys_clk);
         req_valid <= 1'b1;
         req_write <= w;
         req_addr <= a;
         req_wdata <= d;
         @(posedge sys_clk);
         req_valid <= 1'b0;
         req_addr <= ~a;
         req_wdata <= ~d;
         for (n = 0; n < 4 && !ok; n = n + 1) begin
            @(posedge sys_clk);
            if (rsp_valid === 1'b1) begin
               rd = rsp_rdata;
               er = rsp_error;
               ok = 1'b1;
            end
         end
      end
   endtask
endmodule // ctirb_dbg_model

// ---- tb/ctirb_bank_checker.sv ----
/* Port checker of the identity register bank.
   Bound to ctirb_bank; sees its ports only. */
`timescale 1ns/1ps
module ctirb_bank_checker (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        req_valid,
   input wire        req_write,
   input wire [11:0] req_addr,
   input wire        powered_up_status_bit,
   input wire        double_lock_status_bit,
   input wire        rsp_valid,
   input wire [31:0] rsp_rdata,
   input wire        rsp_error,
   input wire [2:0]  rsp_perm,
   input wire        sticky_debug_disabled_bit
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(a); req_valid && !req_write && req_addr == a; endsequence
   property p_ans; req_valid |=> rsp_valid; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_cap; s_rd(12'hFC8) |=> rsp_rdata == 32'h01040A00 && !rsp_error; endproperty
   a_cap: assert property (p_cap) else $error("capability value");
   property p_itc; s_rd(12'hF00) |=> rsp_rdata == 32'h0; endproperty
   a_itc: assert property (p_itc) else $error("integration value");
   property p_pid2; s_rd(12'hFE8) |=> rsp_rdata[31:8] == 24'h0 && rsp_rdata[3] && !rsp_error;
   endproperty
   a_pid2: assert property (p_pid2) else $error("identity 2 value");
   property p_pid3; s_rd(12'hFEC) |=> rsp_rdata[31:8] == 24'h0; endproperty
   a_pid3: assert property (p_pid3) else $error("identity 3 value");
   property p_pid4; s_rd(12'hFD0) |=> rsp_rdata[31:4] == 28'h0; endproperty
   a_pid4: assert property (p_pid4) else $error("identity 4 value");
   property p_aff; s_rd(12'hFA8) |=> rsp_rdata[31:24] == 8'h0 && rsp_rdata[15:0] == 16'h8000;
   endproperty
   a_aff: assert property (p_aff) else $error("affinity value");
   property p_wr; req_valid && req_write |=> rsp_rdata == 32'h0; endproperty
   a_wr: assert property (p_wr) else $error("write returned data");
   property p_off; !powered_up_status_bit [*5] |=> rsp_perm == 3'h0; endproperty
   a_off: assert property (p_off) else $error("off not chosen");
   property p_dlk; (powered_up_status_bit && double_lock_status_bit) [*5] |=> rsp_perm == 3'h1;
   endproperty
   a_dlk: assert property (p_dlk) else $error("double lock not chosen");
   property p_stk; $rose(sticky_debug_disabled_bit) |-> $past(req_valid); endproperty
   a_stk: assert property (p_stk) else $error("sticky set without access");
endmodule // ctirb_bank_checker
bind ctirb_bank ctirb_bank_checker i_ctirb_bank_checker (.sys_clk(sys_clk), .rst_n(rst_n),
   .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
   .powered_up_status_bit(powered_up_status_bit), .double_lock_status_bit(double_lock_status_bit),
   .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .rsp_perm(rsp_perm),
   .sticky_debug_disabled_bit(sticky_debug_disabled_bit));

// ---- tb/tb.sv ----
/* Self-checking bench of the identity register bank.
   Assumes the debugger model drives the request port. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   localparam [19:0] CTAB = 20'h6EA89;
   reg         sys_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [7:0]  aff_in = 8'h00;
   reg  [3:0]  cond = 4'h0;
   reg         sticky_clear = 1'b0;
   wire        req_valid, req_write, rsp_valid, rsp_error, sticky;
   wire [11:0] req_addr;
   wire [31:0] req_wdata, rsp_rdata;
   wire [2:0]  rsp_perm;
   integer     err_count = 0, samples_checked = 0, i, n;
   reg  [31:0] rd;
   reg         er, ok;
   always #2 sys_clk = ~sys_clk;
   // Identity parameter values are arbitrary
   ctirb_bank #(.PID2_REVISION(4'h5), .PID2_DESIGNER_HI(3'h6), .PID3_MINOR_REV(4'h9),
      .PID3_CUSTOMER(4'hC), .PID4_CONT_CODE(4'hA)) i_ctirb_bank (.sys_clk(sys_clk),
      .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_error(rsp_error), .rsp_perm(rsp_perm), .cluster_level2_affinity_in(aff_in),
      .powered_up_status_bit(cond[3]), .double_lock_status_bit(cond[2]),
      .os_lock_status_bit(cond[1]), .debug_allowed(cond[0]), .sticky_clear(sticky_clear),
      .sticky_debug_disabled_bit(sticky));
   ctirb_dbg_model dbg (.sys_clk(sys_clk), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_error(rsp_error));
   task report_and_stop;
      begin
         if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task acc(input w, input [11:0] a, input [31:0] e, input ee);
      begin
         dbg.xfer(w, a, 32'hFFFFFFFF, rd, er, ok);
         if (!ok) begin
            err_count++;
            report_and_stop;
         end else begin
            `CHK(rd, e)
            `CHK(er, ee)
         end
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      cond <= 4'h9;
      aff_in <= 8'hA5;
      repeat (8) @(posedge sys_clk);
      acc(1'b0, 12'hF00, 32'h0, 1'b0);
      acc(1'b0, 12'hFA8, 32'h00A58000, 1'b0);
      acc(1'b0, 12'hFC8, 32'h01040A00, 1'b0);
      acc(1'b0, 12'hFD0, 32'h0000000A, 1'b0);
      acc(1'b0, 12'hFE8, 32'h0000005E, 1'b0);
      acc(1'b0, 12'hFEC, 32'h0000009C, 1'b0);
      acc(1'b1, 12'hFC8, 32'h0, 1'b0);
      acc(1'b0, 12'hFC8, 32'h01040A00, 1'b0);
      acc(1'b0, 12'h100, 32'h0, 1'b1);
      for (i = 0; i < 5; i++) begin
         cond <= CTAB[19-4*i -: 4];
         for (n = 0; n < 12 && rsp_perm !== i[2:0]; n++) @(posedge sys_clk);
         `CHK(rsp_perm, i[2:0])
         acc(1'b0, 12'hFE8, 32'h0000005E, 1'b0);
         `CHK(sticky, 1'b0)
         acc(1'b0, 12'h104, 32'h0, 1'b1);
         `CHK(sticky, i == 3)
         sticky_clear <= 1'b1;
         @(posedge sys_clk);
         sticky_clear <= 1'b0;
         @(posedge sys_clk);
      end
      aff_in <= 8'h3C;
      repeat (8) @(posedge sys_clk);
      acc(1'b0, 12'hFA8, 32'h003C8000, 1'b0);
      report_and_stop;
   end
endmodule // tb
